// File: rtl/ccr_pkg.sv
// constants, register map and field layout of the common control register bank
package ccr_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int unsigned ADR_W   = 20;
	localparam int unsigned IDX_W   = 18;
	localparam int unsigned DAT_W   = 32;
	localparam int unsigned REG_W   = 8;
	localparam int unsigned SEL_W   = 4;
	localparam int unsigned CHAN_N  = 4;
	localparam int unsigned ALARM_W = 8;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_ERR_SEL_CELL   = 18'h30A05;
	localparam logic [IDX_W-1:0] IDX_RESET_CTRL     = 18'h30A06;
	localparam logic [IDX_W-1:0] IDX_TX_DONE        = 18'h30A07;
	localparam logic [IDX_W-1:0] IDX_ALARM_SUMMARY  = 18'h30A08;
	localparam logic [IDX_W-1:0] IDX_B1_COUNT       = 18'h30A09;
	localparam logic [IDX_W-1:0] IDX_CELL_BIP_COUNT = 18'h30A0A;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS     = 18'h30A10;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK       = 18'h30A11;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned F_CHSEL_LSB   = 0;
	localparam int unsigned F_CHSEL_W     = 3;
	localparam int unsigned F_CELL_A      = 4;
	localparam int unsigned F_CELL_B      = 6;
	localparam int unsigned F_PHASE_LSB   = 5;
	localparam int unsigned F_PHASE_W     = 2;
	localparam int unsigned F_SOFT_RESET  = 7;
	localparam int unsigned F_TX_DONE     = 7;
	localparam int unsigned F_ALARM_BD    = 0;
	localparam int unsigned F_ALARM_BC    = 1;
	localparam int unsigned F_ALARM_AD    = 4;
	localparam int unsigned F_ALARM_AC    = 5;
	localparam int unsigned F_IRQ_TX_DONE = 0;
	localparam int unsigned F_IRQ_ALARM   = 1;
	localparam int unsigned F_IRQ_B1_FULL = 2;
	localparam int unsigned IRQ_W         = 3;

	// writable bits of each register, reserved bits stay zero
	localparam logic [REG_W-1:0] WMASK_ERR_SEL_CELL = 8'h57;
	localparam logic [REG_W-1:0] WMASK_RESET_CTRL   = 8'hE0;
	localparam logic [REG_W-1:0] WMASK_TX_DONE      = 8'h80;

	// ------------------------------------------------------------
	// reset values and counter saturation limit
	// ------------------------------------------------------------
	localparam logic [REG_W-1:0] RST_REG   = 8'h00;
	localparam logic [REG_W-1:0] CNT_MAX   = 8'hFF;
	localparam logic [IRQ_W-1:0] RST_IRQ   = 3'h0;

	// ------------------------------------------------------------
	// channel selector codes and channel order on the input vectors
	// ------------------------------------------------------------
	localparam logic [F_CHSEL_W-1:0] CHSEL_AC = 3'h2;
	localparam logic [F_CHSEL_W-1:0] CHSEL_AD = 3'h3;
	localparam logic [F_CHSEL_W-1:0] CHSEL_BC = 3'h6;
	localparam logic [F_CHSEL_W-1:0] CHSEL_BD = 3'h7;
	localparam int unsigned CH_AC = 0;
	localparam int unsigned CH_AD = 1;
	localparam int unsigned CH_BC = 2;
	localparam int unsigned CH_BD = 3;

	// soft reset delay line length
	localparam int unsigned PHASE_N = 4;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ACK
	} bus_state_t;

endpackage : ccr_pkg

// File: rtl/core_common_control_regs.sv
// common control and status register bank with wishbone slave port
//
// Notes on behaviour
// - selector codes pick counter channel AC/AD/BC/BD
// - bit 4 enables cell mode group A
// - bit 6 enables cell mode group B
// - two bit phase delays the soft reset
// - soft reset clears core, not software registers
// - soft reset leaves serializer registers untouched
// - rising edge of done bit signals setup
// - summary bit is OR of channel alarms
// - any summary bit raises system alarm
// - control and summary registers reset to zero
// - B1 counter counts selected channel, clears on read
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module core_common_control_regs
	import ccr_pkg::*;
(
	input  wire logic                       REF_CLK,
	input  wire logic                       RSTN,
	input  wire logic                       WB_CYC_I,
	input  wire logic                       WB_STB_I,
	input  wire logic                       WB_WE_I,
	input  wire logic [ADR_W-1:0]           WB_ADR_I,
	input  wire logic [SEL_W-1:0]           WB_SEL_I,
	input  wire logic [DAT_W-1:0]           WB_DAT_I,
	output logic      [DAT_W-1:0]           WB_DAT_O,
	output logic                            WB_ACK_O,
	input  wire logic [CHAN_N*ALARM_W-1:0]  CHAN_ALARM_BITS,
	input  wire logic [CHAN_N-1:0]          B1_ERR_PULSE,
	input  wire logic [CHAN_N-1:0]          CELL_BIP_ERR_PULSE,
	output logic      [F_CHSEL_W-1:0]       COUNTER_CHANNEL_SELECT,
	output logic                            GROUP_A_CELL_ENABLE,
	output logic                            GROUP_B_CELL_ENABLE,
	output logic                            CORE_SOFT_RESET,
	output logic                            TX_SETUP_DONE,
	output logic                            SYS_ALARM,
	output logic                            IRQ
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	bus_state_t         bus_q;
	bus_state_t         bus_d;
	logic [DAT_W-1:0]   rdat_q;
	logic [DAT_W-1:0]   rdat_d;
	logic [REG_W-1:0]   sel_cell_q;
	logic [REG_W-1:0]   sel_cell_d;
	logic [REG_W-1:0]   rst_ctrl_q;
	logic [REG_W-1:0]   rst_ctrl_d;
	logic [REG_W-1:0]   tx_done_q;
	logic [REG_W-1:0]   tx_done_d;
	logic               tx_pulse_q;
	logic               tx_pulse_d;
	logic [REG_W-1:0]   alarm_sum_q;
	logic [REG_W-1:0]   alarm_sum_d;
	logic               sys_alarm_q;
	logic               sys_alarm_d;
	logic [REG_W-1:0]   b1_cnt_q;
	logic [REG_W-1:0]   b1_cnt_d;
	logic [REG_W-1:0]   bip_cnt_q;
	logic [REG_W-1:0]   bip_cnt_d;
	logic [IRQ_W-1:0]   irq_stat_q;
	logic [IRQ_W-1:0]   irq_stat_d;
	logic [IRQ_W-1:0]   irq_mask_q;
	logic [IRQ_W-1:0]   irq_mask_d;
	logic               irq_q;
	logic               irq_d;

	logic               req;
	logic               take;
	logic               wr_take;
	logic               rd_take;
	logic               lane0;
	logic [IDX_W-1:0]   idx;
	logic [REG_W-1:0]   wbyte;
	logic               hit_sel_cell;
	logic               hit_rst_ctrl;
	logic               hit_tx_done;
	logic               hit_alarm;
	logic               hit_b1;
	logic               hit_bip;
	logic               hit_irq_stat;
	logic               hit_irq_mask;
	logic [REG_W-1:0]   rd_mux;
	logic               chan_valid;
	logic [1:0]         chan_idx;
	logic [CHAN_N-1:0]  chan_alarm;
	logic               b1_hit;
	logic               bip_hit;
	logic               b1_clr;
	logic               bip_clr;
	logic [IRQ_W-1:0]   irq_events;
	logic [IRQ_W-1:0]   irq_w1c;
	logic               soft_reset_dly;

	// ------------------------------------------------------------
	// wishbone decode
	// ------------------------------------------------------------
	// a request is answered one clock after it is seen; the write and
	// any clear-on-read side effect happen at the edge that samples ack
	assign req     = WB_CYC_I & WB_STB_I;
	assign take    = req & (bus_q == BUS_ACK);
	assign wr_take = take & WB_WE_I & lane0;
	assign rd_take = take & ~WB_WE_I;
	assign lane0   = WB_SEL_I[0];
	assign idx     = WB_ADR_I[ADR_W-1:2];
	assign wbyte   = WB_DAT_I[REG_W-1:0];

	assign hit_sel_cell = (idx == IDX_ERR_SEL_CELL);
	assign hit_rst_ctrl = (idx == IDX_RESET_CTRL);
	assign hit_tx_done  = (idx == IDX_TX_DONE);
	assign hit_alarm    = (idx == IDX_ALARM_SUMMARY);
	assign hit_b1       = (idx == IDX_B1_COUNT);
	assign hit_bip      = (idx == IDX_CELL_BIP_COUNT);
	assign hit_irq_stat = (idx == IDX_IRQ_STATUS);
	assign hit_irq_mask = (idx == IDX_IRQ_MASK);

	// unmapped addresses are acknowledged and read as zero
	assign rd_mux = hit_sel_cell ? sel_cell_q :
	                hit_rst_ctrl ? rst_ctrl_q :
	                hit_tx_done  ? tx_done_q :
	                hit_alarm    ? alarm_sum_q :
	                hit_b1       ? b1_cnt_q :
	                hit_bip      ? bip_cnt_q :
	                hit_irq_stat ? {{(REG_W-IRQ_W){1'b0}}, irq_stat_q} :
	                hit_irq_mask ? {{(REG_W-IRQ_W){1'b0}}, irq_mask_q} :
	                RST_REG;

	always_comb begin
		bus_d  = bus_q;
		rdat_d = rdat_q;
		unique case (bus_q)
			BUS_IDLE: begin
				if (req) begin
					bus_d  = BUS_ACK;
					rdat_d = {{(DAT_W-REG_W){1'b0}}, rd_mux};
				end
			end
			BUS_ACK: begin
				bus_d  = BUS_IDLE;
				rdat_d = '0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	// reserved bits are masked off on write so they always read zero
	assign sel_cell_d = (wr_take & hit_sel_cell) ?
	                    (wbyte & WMASK_ERR_SEL_CELL) : sel_cell_q;
	assign rst_ctrl_d = (wr_take & hit_rst_ctrl) ?
	                    (wbyte & WMASK_RESET_CTRL) : rst_ctrl_q;
	assign tx_done_d  = (wr_take & hit_tx_done) ?
	                    (wbyte & WMASK_TX_DONE) : tx_done_q;

	// only a zero-to-one change of the stored bit counts; rewriting one
	// while it is already set gives nothing, so software must clear first
	assign tx_pulse_d = tx_done_d[F_TX_DONE] & ~tx_done_q[F_TX_DONE];

	// ------------------------------------------------------------
	// channel selector and error counters
	// ------------------------------------------------------------
	assign chan_valid = (sel_cell_q[F_CHSEL_W-1:0] == CHSEL_AC) |
	                    (sel_cell_q[F_CHSEL_W-1:0] == CHSEL_AD) |
	                    (sel_cell_q[F_CHSEL_W-1:0] == CHSEL_BC) |
	                    (sel_cell_q[F_CHSEL_W-1:0] == CHSEL_BD);
	assign chan_idx = (sel_cell_q[F_CHSEL_W-1:0] == CHSEL_AC) ? 2'(CH_AC) :
	                  (sel_cell_q[F_CHSEL_W-1:0] == CHSEL_AD) ? 2'(CH_AD) :
	                  (sel_cell_q[F_CHSEL_W-1:0] == CHSEL_BC) ? 2'(CH_BC) :
	                  2'(CH_BD);

	// unlisted selector codes monitor no channel
	assign b1_hit  = chan_valid & B1_ERR_PULSE[chan_idx];
	assign bip_hit = chan_valid & CELL_BIP_ERR_PULSE[chan_idx];
	assign b1_clr  = rd_take & hit_b1;
	assign bip_clr = rd_take & hit_bip;

	// counters saturate rather than wrap so a read never shows a small
	// count after a burst; an error on the clearing edge is kept as one
	always_comb begin
		b1_cnt_d = b1_cnt_q;
		if (b1_clr) begin
			b1_cnt_d = {{(REG_W-1){1'b0}}, b1_hit};
		end else if (b1_hit && (b1_cnt_q != CNT_MAX)) begin
			b1_cnt_d = b1_cnt_q + 8'h01;
		end
	end

	always_comb begin
		bip_cnt_d = bip_cnt_q;
		if (bip_clr) begin
			bip_cnt_d = {{(REG_W-1){1'b0}}, bip_hit};
		end else if (bip_hit && (bip_cnt_q != CNT_MAX)) begin
			bip_cnt_d = bip_cnt_q + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// alarm summary
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CHAN_N; g++) begin : g_alarm_or
			assign chan_alarm[g] = |CHAN_ALARM_BITS[g*ALARM_W +: ALARM_W];
		end
	endgenerate

	always_comb begin
		alarm_sum_d = RST_REG;
		alarm_sum_d[F_ALARM_BD] = chan_alarm[CH_BD];
		alarm_sum_d[F_ALARM_BC] = chan_alarm[CH_BC];
		alarm_sum_d[F_ALARM_AD] = chan_alarm[CH_AD];
		alarm_sum_d[F_ALARM_AC] = chan_alarm[CH_AC];
	end

	assign sys_alarm_d = |alarm_sum_q;

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------
	assign irq_events[F_IRQ_TX_DONE] = tx_pulse_q;
	assign irq_events[F_IRQ_ALARM]   = sys_alarm_d & ~sys_alarm_q;
	assign irq_events[F_IRQ_B1_FULL] = b1_hit & (b1_cnt_q == (CNT_MAX - 8'h01));

	assign irq_w1c    = (wr_take & hit_irq_stat) ? wbyte[IRQ_W-1:0] : RST_IRQ;
	// a new event on the clearing edge keeps its bit set
	assign irq_stat_d = (irq_stat_q & ~irq_w1c) | irq_events;
	assign irq_mask_d = (wr_take & hit_irq_mask) ? wbyte[IRQ_W-1:0] : irq_mask_q;
	assign irq_d      = |(irq_stat_q & irq_mask_q);

	// ------------------------------------------------------------
	// soft reset phase delay
	// ------------------------------------------------------------
	// the delayed reset only leaves on a port; nothing in this bank,
	// and no serializer register, listens to it
	soft_reset_delay u_soft_reset_delay (
		.clk            (REF_CLK),
		.rst_n          (RSTN),
		.soft_reset_req (rst_ctrl_q[F_SOFT_RESET]),
		.phase_sel      (rst_ctrl_q[F_PHASE_LSB +: F_PHASE_W]),
		.soft_reset_out (soft_reset_dly)
	);

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			bus_q      <= BUS_IDLE;
			rdat_q     <= '0;
			sel_cell_q <= RST_REG;
			rst_ctrl_q <= RST_REG;
			tx_done_q  <= RST_REG;
			tx_pulse_q <= 1'b0;
		end else begin
			bus_q      <= bus_d;
			rdat_q     <= rdat_d;
			sel_cell_q <= sel_cell_d;
			rst_ctrl_q <= rst_ctrl_d;
			tx_done_q  <= tx_done_d;
			tx_pulse_q <= tx_pulse_d;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			alarm_sum_q <= RST_REG;
			sys_alarm_q <= 1'b0;
			b1_cnt_q    <= RST_REG;
			bip_cnt_q   <= RST_REG;
		end else begin
			alarm_sum_q <= alarm_sum_d;
			sys_alarm_q <= sys_alarm_d;
			b1_cnt_q    <= b1_cnt_d;
			bip_cnt_q   <= bip_cnt_d;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_stat_q <= RST_IRQ;
			irq_mask_q <= RST_IRQ;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			irq_q      <= irq_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign WB_DAT_O               = rdat_q;
	assign WB_ACK_O               = (bus_q == BUS_ACK);
	assign COUNTER_CHANNEL_SELECT = sel_cell_q[F_CHSEL_LSB +: F_CHSEL_W];
	assign GROUP_A_CELL_ENABLE    = sel_cell_q[F_CELL_A];
	assign GROUP_B_CELL_ENABLE    = sel_cell_q[F_CELL_B];
	assign CORE_SOFT_RESET        = soft_reset_dly;
	assign TX_SETUP_DONE          = tx_pulse_q;
	assign SYS_ALARM              = sys_alarm_q;
	assign IRQ                    = irq_q;

endmodule : core_common_control_regs

`default_nettype wire

// File: rtl/soft_reset_delay.sv
// delay line that places the soft reset on one of four phases
`timescale 1ns/100ps
`default_nettype none

module soft_reset_delay
	import ccr_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 soft_reset_req,
	input  wire logic [F_PHASE_W-1:0] phase_sel,
	output logic                      soft_reset_out
);

	logic [PHASE_N-1:0] stage_q;
	logic [PHASE_N-1:0] stage_d;
	logic               out_q;
	logic               out_d;

	// ------------------------------------------------------------
	// delay stages
	// ------------------------------------------------------------
	assign stage_d = {stage_q[PHASE_N-2:0], soft_reset_req};

	// phase code picks how many extra clocks the reset lags the bit
	assign out_d = stage_q[phase_sel];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= '0;
			out_q   <= 1'b0;
		end else begin
			stage_q <= stage_d;
			out_q   <= out_d;
		end
	end

	assign soft_reset_out = out_q;

endmodule : soft_reset_delay

`default_nettype wire

// File: sim/ccr_properties.sv
// port checker for the common control register bank
`timescale 1ns/100ps
`default_nettype none

module ccr_properties
	import ccr_pkg::*;
(
	input wire logic                      REF_CLK,
	input wire logic                      RSTN,
	input wire logic                      WB_CYC_I,
	input wire logic                      WB_STB_I,
	input wire logic                      WB_WE_I,
	input wire logic [ADR_W-1:0]          WB_ADR_I,
	input wire logic [SEL_W-1:0]          WB_SEL_I,
	input wire logic [DAT_W-1:0]          WB_DAT_I,
	input wire logic [DAT_W-1:0]          WB_DAT_O,
	input wire logic                      WB_ACK_O,
	input wire logic [CHAN_N*ALARM_W-1:0] CHAN_ALARM_BITS,
	input wire logic [F_CHSEL_W-1:0]      COUNTER_CHANNEL_SELECT,
	input wire logic                      GROUP_A_CELL_ENABLE,
	input wire logic                      GROUP_B_CELL_ENABLE,
	input wire logic                      CORE_SOFT_RESET,
	input wire logic                      TX_SETUP_DONE,
	input wire logic                      SYS_ALARM
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	wire logic             wr_hit = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
	wire logic [IDX_W-1:0] widx = WB_ADR_I[ADR_W-1:2];
	wire logic             sel_wr = wr_hit && widx == IDX_ERR_SEL_CELL;
	wire logic             rst_wr = wr_hit && widx == IDX_RESET_CTRL;
	wire logic             tx_wr = wr_hit && widx == IDX_TX_DONE && WB_DAT_I[F_TX_DONE];
	logic                  soft_q;
	logic [1:0]            ph_q;
	logic [3:0]            cnt_q;
	logic [1:0]            up_q;

	// cnt_q counts edges since the last reset-control write
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			soft_q <= 1'b0;
			ph_q <= 2'h0;
			cnt_q <= 4'h0;
			up_q <= 2'h0;
		end else begin
			if (up_q != 2'h3)
				up_q <= up_q + 2'h1;
			if (rst_wr) begin
				soft_q <= WB_DAT_I[F_SOFT_RESET];
				ph_q <= WB_DAT_I[6:5];
				cnt_q <= 4'h0;
			end else if (cnt_q != 4'hF)
				cnt_q <= cnt_q + 4'h1;
		end
	end

	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	ack_latency_a: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
		else $error("request not answered in the next cycle");
	idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
		else $error("read data outside ack");
	upper_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	sel_fields_a: assert property (sel_wr |=>
		COUNTER_CHANNEL_SELECT == $past(WB_DAT_I[2:0]) && GROUP_A_CELL_ENABLE ==
		$past(WB_DAT_I[F_CELL_A]) && GROUP_B_CELL_ENABLE == $past(WB_DAT_I[F_CELL_B]))
		else $error("selector or cell enable not taken from write");
	soft_phase_a: assert property ($rose(CORE_SOFT_RESET) |-> cnt_q == {2'h0, ph_q} + 4'h2)
		else $error("soft reset rose on wrong phase");
	soft_hold_a: assert property (cnt_q >= 4'h6 |-> CORE_SOFT_RESET == soft_q)
		else $error("soft reset output differs from its bit");
	tx_edge_a: assert property ($rose(TX_SETUP_DONE) |-> $past(tx_wr) || $past(tx_wr, 2))
		else $error("setup done pulse without a write of one");
	tx_pulse_a: assert property (TX_SETUP_DONE |=> !TX_SETUP_DONE)
		else $error("setup done longer than one cycle");
	alarm_or_a: assert property (up_q == 2'h3 |-> SYS_ALARM == $past(|CHAN_ALARM_BITS, 2))
		else $error("system alarm does not follow channel alarms");
endmodule : ccr_properties

bind core_common_control_regs ccr_properties chk_i (
	.REF_CLK(REF_CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CHAN_ALARM_BITS(CHAN_ALARM_BITS),
	.COUNTER_CHANNEL_SELECT(COUNTER_CHANNEL_SELECT), .GROUP_A_CELL_ENABLE(GROUP_A_CELL_ENABLE),
	.GROUP_B_CELL_ENABLE(GROUP_B_CELL_ENABLE), .CORE_SOFT_RESET(CORE_SOFT_RESET),
	.TX_SETUP_DONE(TX_SETUP_DONE), .SYS_ALARM(SYS_ALARM));

`default_nettype wire

// File: sim/link_side_model.sv
// far-side model: per-channel alarm levels and error pulses
`timescale 1ns/100ps
`default_nettype none

module link_side_model (
	input  wire logic        clk,
	output logic      [31:0] alarm,
	output logic      [3:0]  b1,
	output logic      [3:0]  bip
);
	initial begin
		alarm = 32'h0;
		b1 = 4'h0;
		bip = 4'h0;
	end

	// channel i pulses i+1 times, so every channel gives a distinct count
	task automatic burst();
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			b1 <= 4'hF << k;
			bip <= 4'hF << k;
		end
		@(posedge clk);
		b1 <= 4'h0;
		bip <= 4'h0;
	endtask : burst

	task automatic set_alarm(input logic [31:0] v);
		@(posedge clk);
		alarm <= v;
	endtask : set_alarm
endmodule : link_side_model

`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the common control register bank
`timescale 1ns/100ps
`default_nettype none

module testbench
	import ccr_pkg::*;
;
	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	logic             cyc = 1'b0;
	logic             stb = 1'b0;
	logic             we = 1'b0;
	logic [ADR_W-1:0] adr = '0;
	logic [SEL_W-1:0] sel = '0;
	logic [DAT_W-1:0] wdat = '0;
	logic [DAT_W-1:0] rdat;
	logic [31:0]      alarm;
	logic [3:0]       b1;
	logic [3:0]       bip;
	logic [2:0]       chsel;
	logic             ack, cell_a, cell_b, srst, txd, salarm, irq;
	int               error_cnt = 0;
	int               checks = 0;

	always #4 clk = ~clk;

	link_side_model far (.clk(clk), .alarm(alarm), .b1(b1), .bip(bip));

	core_common_control_regs uut (
		.REF_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.CHAN_ALARM_BITS(alarm), .B1_ERR_PULSE(b1), .CELL_BIP_ERR_PULSE(bip),
		.COUNTER_CHANNEL_SELECT(chsel), .GROUP_A_CELL_ENABLE(cell_a),
		.GROUP_B_CELL_ENABLE(cell_b), .CORE_SOFT_RESET(srst), .TX_SETUP_DONE(txd),
		.SYS_ALARM(salarm), .IRQ(irq));

	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// reads after the edge see pre-edge values, so ack and data pair up
	task automatic bus(input logic w, input logic [IDX_W-1:0] i, input logic [7:0] d,
			input logic [3:0] s, output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'h0};
		sel <= s;
		wdat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, i, d, 4'h1, r);
	endtask : wr

	task automatic rd(input string n, input logic [IDX_W-1:0] i, input logic [7:0] e);
		logic [31:0] r;
		bus(1'b0, i, 8'h00, 4'h1, r);
		chk(n, r, {24'h0, e});
	endtask : rd

	task automatic hi_cnt(output int h);
		h = 0;
		repeat (4) begin
			@(negedge clk);
			h += (txd === 1'b1);
		end
	endtask : hi_cnt

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_fields();
		logic [31:0] r;
		rd("ctrl0", IDX_ERR_SEL_CELL, 8'h00);
		rd("ctrl1", IDX_RESET_CTRL, 8'h00);
		rd("txdone", IDX_TX_DONE, 8'h00);
		rd("summary", IDX_ALARM_SUMMARY, 8'h00);
		chk("outs", {chsel, cell_a, cell_b, srst, txd, salarm, irq}, 32'h0);
		wr(IDX_ERR_SEL_CELL, 8'hFF);
		@(negedge clk);
		chk("chsel", chsel, 32'h7);
		chk("cells", {cell_b, cell_a}, 32'h3);
		rd("ctrl0 rsvd", IDX_ERR_SEL_CELL, 8'h57);
		bus(1'b1, IDX_ERR_SEL_CELL, 8'h10, 4'h0, r);
		rd("no lane", IDX_ERR_SEL_CELL, 8'h57);
		wr(IDX_ERR_SEL_CELL, 8'h10);
		@(negedge clk);
		chk("cells", {cell_b, cell_a}, 32'h1);
		wr(IDX_RESET_CTRL, 8'h1F);
		rd("ctrl1 rsvd", IDX_RESET_CTRL, 8'h00);
		wr(IDX_TX_DONE, 8'h7F);
		rd("txdone rsvd", IDX_TX_DONE, 8'h00);
		rd("unmapped", 18'h30A0F, 8'h00);
	endtask : t_fields

	task automatic t_count();
		logic [2:0] code [5] = '{CHSEL_AC, CHSEL_AD, CHSEL_BC, CHSEL_BD, 3'h0};
		for (int c = 0; c < 5; c++) begin
			wr(IDX_ERR_SEL_CELL, {5'h0, code[c]});
			far.burst();
			rd("b1 count", IDX_B1_COUNT, 8'((c < 4) ? c + 1 : 0));
			rd("bip count", IDX_CELL_BIP_COUNT, 8'((c < 4) ? c + 1 : 0));
			rd("b1 cleared", IDX_B1_COUNT, 8'h00);
		end
	endtask : t_count

	task automatic t_soft();
		int n;
		wr(IDX_ERR_SEL_CELL, 8'h45);
		for (int p = 0; p < 4; p++) begin
			wr(IDX_RESET_CTRL, {1'b1, 2'(p), 5'h0});
			n = 0;
			// a level set at edge k is only seen after edge k+1
			while (srst !== 1'b1 && n < 10) begin
				@(posedge clk);
				n++;
			end
			chk("soft delay", n, p + 3);
			rd("ctrl kept", IDX_ERR_SEL_CELL, 8'h45);
			rd("ctrl1", IDX_RESET_CTRL, {1'b1, 2'(p), 5'h0});
			wr(IDX_RESET_CTRL, 8'h00);
			repeat (6) @(posedge clk);
			chk("soft off", srst, 32'h0);
		end
	endtask : t_soft

	task automatic t_tx();
		int h;
		wr(IDX_IRQ_MASK, 8'h00);
		wr(IDX_TX_DONE, 8'h00);
		wr(IDX_TX_DONE, 8'h80);
		hi_cnt(h);
		chk("tx pulse", h, 1);
		wr(IDX_TX_DONE, 8'h80);
		hi_cnt(h);
		chk("tx level", h, 0);
		rd("irq st", IDX_IRQ_STATUS, 8'h01);
		chk("irq masked", irq, 32'h0);
		wr(IDX_IRQ_MASK, 8'h01);
		repeat (2) @(negedge clk);
		chk("irq on", irq, 32'h1);
		wr(IDX_IRQ_STATUS, 8'h01);
		repeat (2) @(negedge clk);
		chk("irq off", irq, 32'h0);
	endtask : t_tx

	task automatic t_alarm();
		int pos [4] = '{5, 4, 1, 0};
		for (int c = 0; c < 4; c++) begin
			far.set_alarm(32'h1 << (9 * c));
			repeat (3) @(negedge clk);
			chk("sys alarm", salarm, 32'h1);
			rd("summary", IDX_ALARM_SUMMARY, 8'h01 << pos[c]);
		end
		far.set_alarm(32'h0);
		repeat (3) @(negedge clk);
		chk("sys alarm", salarm, 32'h0);
		rd("summary", IDX_ALARM_SUMMARY, 8'h00);
		rd("irq st", IDX_IRQ_STATUS, 8'h02);
		wr(IDX_IRQ_MASK, 8'h02);
		repeat (2) @(negedge clk);
		chk("irq alarm", irq, 32'h1);
		wr(IDX_IRQ_STATUS, 8'h02);
		rd("irq st", IDX_IRQ_STATUS, 8'h00);
	endtask : t_alarm

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_fields();
		t_count();
		t_soft();
		t_tx();
		t_alarm();
		finish_test();
	end

	// the full run takes well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
endmodule : testbench

`default_nettype wire
